// ===== drf_device.sv
// dram controller end: strobe timing, refresh counter, mode capture
// assumes the host drives all interface inputs from the same clock
//
// Implementation choices: the APB register port and the placing of the registers.

// Summary of operation
// - cas held while matching extend inputs asserted
// - scrub refresh cas timing ignores extend inputs
// - ras one or two clocks after grant
// - grant delay waits for precharge completion
// - refresh request on write pin when enabled
// - clear refresh counter after 500 ns
// - no internal refresh within 13 to 14.5 us
// - host resets for sixteen edges before use
// - column increment active high, tied low unused
// - extend zero low gives old-style behaviour
module drf_device
  import drf_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  drf_if.device BUS,
  output logic O_RAS_N,
  output logic [3:0] O_CAS_N,
  output logic O_WE_N,
  output logic O_REFRESH_PENDING,
  output logic O_CONFIG_VALID
);
  drf_dev_state_t state_q;
  logic [4:0] rst_cnt_q;
  logic [3:0] clr_cnt_q;
  logic [CNT_W-1:0] ref_cnt_q;
  logic [CNT_W-1:0] ref_period;
  logic [CNT_W-1:0] step_cnt_q;
  logic [1:0] prech_q;
  logic grant_q;
  logic pending_q;
  logic row_delay_q;
  logic [3:0] div_q;
  logic pipe_q;
  logic scrub_q;
  logic ext_en_q;
  logic cfg_valid_q;
  logic ras_q;
  logic [3:0] cas_q;
  logic we_q;
  logic hw_reset;
  logic programming;
  logic clear_active;
  logic period_hit;
  logic grant_chg;
  logic sel_req;
  logic prech_done;
  logic route_refresh_request_out;
  logic [3:0] ext_asserted;

  assign hw_reset = (rst_cnt_q == 5'(HW_RESET_EDGES));
  assign programming = !BUS.mode_load_strobe_n && BUS.refresh_disable_n;
  assign clear_active = (clr_cnt_q == 4'(CLEAR_CYC));
  assign ref_period = CNT_W'(REFRESH_MIN_CYC) + CNT_W'(div_q) * CNT_W'(REFRESH_STEP_CYC);
  assign period_hit = (ref_cnt_q == ref_period - CNT_W'(1));
  assign grant_chg = (BUS.port_b_grant != grant_q);
  assign sel_req = BUS.port_b_grant ? !BUS.port_b_access_request_n : !BUS.access_request_n;
  assign prech_done = (prech_q == 2'h0);
  assign route_refresh_request_out = ext_en_q || pipe_q;
  assign ext_asserted = ~BUS.column_extend_input_n;

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      rst_cnt_q <= 5'h00;
    end else if (!BUS.mode_load_strobe_n && !BUS.refresh_disable_n) begin
      if (!hw_reset) begin
        rst_cnt_q <= rst_cnt_q + 5'h01;
      end
    end else begin
      rst_cnt_q <= 5'h00;
    end
  end

  // mode capture; held until next program or reset
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N || hw_reset) begin
      row_delay_q <= 1'b0;
      div_q <= 4'h0;
      pipe_q <= 1'b0;
      scrub_q <= 1'b0;
      ext_en_q <= 1'b0;
      cfg_valid_q <= 1'b0;
    end else if (programming) begin
      row_delay_q <= BUS.row_delay_select_bit;
      div_q <= BUS.refresh_clock_divider_bits;
      pipe_q <= BUS.pipeline_mode;
      scrub_q <= BUS.scrub_mode;
      ext_en_q <= BUS.column_extend_input_n[0];
      cfg_valid_q <= 1'b1;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      clr_cnt_q <= 4'h0;
    end else if (BUS.refresh_disable_n && !BUS.external_refresh_input_n) begin
      if (!clear_active) begin
        clr_cnt_q <= clr_cnt_q + 4'h1;
      end
    end else begin
      clr_cnt_q <= 4'h0;
    end
  end

  // counter halts while refresh is disabled
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N || hw_reset || clear_active) begin
      ref_cnt_q <= '0;
    end else if (BUS.refresh_disable_n) begin
      ref_cnt_q <= period_hit ? '0 : ref_cnt_q + CNT_W'(1);
    end
  end

  // set wins over the clear from a starting refresh
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N || hw_reset || clear_active) begin
      pending_q <= 1'b0;
    end else if (BUS.refresh_disable_n && period_hit) begin
      pending_q <= 1'b1;
    end else if (state_q == DS_IDLE && prech_done && !grant_chg) begin
      pending_q <= 1'b0;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      grant_q <= 1'b0;
    end else begin
      grant_q <= BUS.port_b_grant;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N || hw_reset) begin
      state_q <= DS_IDLE;
      ras_q <= 1'b1;
      cas_q <= 4'hF;
      prech_q <= 2'h0;
      step_cnt_q <= '0;
    end else begin
      if (!prech_done) begin
        prech_q <= prech_q - 2'h1;
      end
      case (state_q)
        DS_IDLE: begin
          if (grant_chg) begin
            if (!row_delay_q && prech_done && sel_req) begin
              ras_q <= 1'b0;
              state_q <= DS_ROW;
            end else begin
              state_q <= DS_GRANT_WAIT;
            end
          end else if (pending_q && prech_done) begin
            ras_q <= 1'b0;
            step_cnt_q <= '0;
            state_q <= scrub_q ? DS_SCRUB : DS_REFRESH;
          end else if (sel_req && prech_done) begin
            ras_q <= 1'b0;
            state_q <= DS_ROW;
          end
        end
        DS_GRANT_WAIT: begin
          if (prech_done) begin
            if (sel_req) begin
              ras_q <= 1'b0;
              state_q <= DS_ROW;
            end else begin
              state_q <= DS_IDLE;
            end
          end
        end
        DS_ROW: begin
          cas_q <= 4'h0;
          state_q <= DS_COL;
        end
        DS_COL: begin
          if (!sel_req) begin
            if (ext_en_q && (ext_asserted != 4'h0)) begin
              cas_q <= ~ext_asserted;
              state_q <= DS_EXTEND;
            end else begin
              ras_q <= 1'b1;
              cas_q <= 4'hF;
              prech_q <= 2'(PRECHARGE_CYC);
              state_q <= DS_IDLE;
            end
          end
        end
        DS_EXTEND: begin
          cas_q <= cas_q | BUS.column_extend_input_n;
          if ((cas_q | BUS.column_extend_input_n) == 4'hF) begin
            ras_q <= 1'b1;
            prech_q <= 2'(PRECHARGE_CYC);
            state_q <= DS_IDLE;
          end
        end
        DS_REFRESH: begin
          step_cnt_q <= step_cnt_q + CNT_W'(1);
          if (step_cnt_q == CNT_W'(REFRESH_RAS_CYC - 1)) begin
            ras_q <= 1'b1;
            prech_q <= 2'(PRECHARGE_CYC);
            state_q <= DS_IDLE;
          end
        end
        DS_SCRUB: begin
          step_cnt_q <= step_cnt_q + CNT_W'(1);
          if (step_cnt_q == CNT_W'(0)) begin
            cas_q <= 4'h0;
          end else if (step_cnt_q == CNT_W'(SCRUB_CAS_CYC)) begin
            ras_q <= 1'b1;
            cas_q <= 4'hF;
            prech_q <= 2'(PRECHARGE_CYC);
            state_q <= DS_IDLE;
          end
        end
        default: begin
          state_q <= DS_IDLE;
        end
      endcase
    end
  end

  // write pin doubles as active-low refresh request
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      we_q <= 1'b1;
    end else if (route_refresh_request_out) begin
      we_q <= !pending_q;
    end else begin
      we_q <= ras_q ? 1'b1 : BUS.write_n;
    end
  end

  assign BUS.ras_n = ras_q;
  assign BUS.cas_n = cas_q;
  assign BUS.we_n = we_q;
  assign O_RAS_N = ras_q;
  assign O_CAS_N = cas_q;
  assign O_WE_N = we_q;
  assign O_REFRESH_PENDING = pending_q;
  assign O_CONFIG_VALID = cfg_valid_q;
endmodule

// ===== drf_pkg.sv
// constants, register map and state types shared by both ends
// assumes one 20 MHz clock common to the controller and its host
package drf_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned HW_RESET_EDGES = 16;
  localparam int unsigned CLEAR_TIME_NS = 500;
  localparam int unsigned CLEAR_CYC = (CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REFRESH_MIN_US = 13;
  localparam int unsigned REFRESH_MAX_US = 15;
  localparam int unsigned REFRESH_MIN_CYC = (REFRESH_MIN_US * 1000 + CLK_PERIOD_NS - 1)
                                            / CLK_PERIOD_NS;
  localparam int unsigned REFRESH_MAX_CYC = (REFRESH_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned REFRESH_STEP_CYC = (REFRESH_MAX_CYC - REFRESH_MIN_CYC) / 15;
  localparam int unsigned PRECHARGE_CYC = 2;
  localparam int unsigned REFRESH_RAS_CYC = 3;
  localparam int unsigned SCRUB_CAS_CYC = 2;
  localparam int unsigned ML_PULSE_CYC = 1;
  localparam int unsigned CNT_W = 9;

  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] MODE_OFS = 8'h04;
  localparam logic [7:0] CMD_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;

  // control register fields
  localparam int unsigned CTRL_REQ_A = 0;
  localparam int unsigned CTRL_REQ_B = 1;
  localparam int unsigned CTRL_GRANT = 2;
  localparam int unsigned CTRL_WRITE = 3;
  localparam int unsigned CTRL_EXT_LSB = 4;
  localparam int unsigned CTRL_COLUMN_INCREMENT = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // mode register fields
  localparam int unsigned MODE_ROWDLY = 0;
  localparam int unsigned MODE_DIV_LSB = 1;
  localparam int unsigned MODE_PIPE = 5;
  localparam int unsigned MODE_SCRUB = 6;
  localparam int unsigned MODE_EXT0_HIGH = 7;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  // command bits
  localparam int unsigned CMD_HWRESET = 0;
  localparam int unsigned CMD_PROGRAM = 1;
  localparam int unsigned CMD_CLEAR = 2;
  // status fields
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_CAS_LSB = 1;
  localparam int unsigned ST_RAS = 5;
  localparam int unsigned ST_WE = 6;
  localparam int unsigned ST_RESET_DONE = 7;

  typedef enum logic [2:0] {
    DS_IDLE, DS_GRANT_WAIT, DS_ROW, DS_COL, DS_EXTEND, DS_REFRESH, DS_SCRUB
  } drf_dev_state_t;

  typedef enum logic [1:0] {
    HS_IDLE, HS_RESET, HS_PROGRAM, HS_CLEAR
  } drf_host_state_t;
endpackage

// ===== drf_if.sv
// pins between the dram controller and the host processor side
// assumes both ends sample on the same clock edge
interface drf_if;
  logic access_request_n;
  logic port_b_access_request_n;
  logic port_b_grant;
  logic write_n;
  logic [3:0] column_extend_input_n;
  logic column_increment;
  logic mode_load_strobe_n;
  logic refresh_disable_n;
  logic external_refresh_input_n;
  logic row_delay_select_bit;
  logic [3:0] refresh_clock_divider_bits;
  logic pipeline_mode;
  logic scrub_mode;
  logic we_n;
  logic ras_n;
  logic [3:0] cas_n;

  modport device(
    input access_request_n, port_b_access_request_n, port_b_grant, write_n,
    input column_extend_input_n, column_increment, mode_load_strobe_n,
    input refresh_disable_n, external_refresh_input_n, row_delay_select_bit,
    input refresh_clock_divider_bits, pipeline_mode, scrub_mode,
    output we_n, ras_n, cas_n
  );
  modport host(
    output access_request_n, port_b_access_request_n, port_b_grant, write_n,
    output column_extend_input_n, column_increment, mode_load_strobe_n,
    output refresh_disable_n, external_refresh_input_n, row_delay_select_bit,
    output refresh_clock_divider_bits, pipeline_mode, scrub_mode,
    input we_n, ras_n, cas_n
  );
endinterface

// ===== drf_host.sv
// host end: apb registers and the reset, program and clear sequences
// assumes the controller end shares I_CLOCK; apb master on same clock
module drf_host
  import drf_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  drf_if.host BUS,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR
);
  drf_host_state_t state_q;
  logic [31:0] ctrl_q;
  logic [31:0] mode_q;
  logic [31:0] prdata_q;
  logic [4:0] cnt_q;
  logic done_q;
  logic mapped;
  logic wr_cmd;
  logic [31:0] status;

  assign mapped = (I_PADDR == CTRL_OFS) || (I_PADDR == MODE_OFS) ||
                  (I_PADDR == CMD_OFS) || (I_PADDR == STATUS_OFS);
  assign wr_cmd = I_PSEL && I_PENABLE && I_PWRITE && (I_PADDR == CMD_OFS);
  assign status = {24'h00_0000, done_q, BUS.we_n, !BUS.ras_n, ~BUS.cas_n,
                   state_q != HS_IDLE};

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      ctrl_q <= CTRL_RESET;
      mode_q <= MODE_RESET;
    end else if (I_PSEL && I_PENABLE && I_PWRITE) begin
      if (I_PADDR == CTRL_OFS) begin
        ctrl_q <= I_PWDATA;
      end else if (I_PADDR == MODE_OFS) begin
        mode_q <= I_PWDATA;
      end
    end
  end

  // read data is fixed at setup so it stands for the access phase
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      prdata_q <= 32'h0000_0000;
    end else if (I_PSEL && !I_PENABLE) begin
      if (I_PADDR == CTRL_OFS) begin
        prdata_q <= ctrl_q;
      end else if (I_PADDR == MODE_OFS) begin
        prdata_q <= mode_q;
      end else if (I_PADDR == STATUS_OFS) begin
        prdata_q <= status;
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // commands while busy are dropped
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      state_q <= HS_IDLE;
      cnt_q <= 5'h00;
      done_q <= 1'b0;
    end else begin
      case (state_q)
        HS_IDLE: begin
          cnt_q <= 5'h00;
          if (wr_cmd && I_PWDATA[CMD_HWRESET]) begin
            state_q <= HS_RESET;
          end else if (wr_cmd && I_PWDATA[CMD_PROGRAM]) begin
            state_q <= HS_PROGRAM;
          end else if (wr_cmd && I_PWDATA[CMD_CLEAR]) begin
            state_q <= HS_CLEAR;
          end
        end
        HS_RESET: begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == 5'(HW_RESET_EDGES - 1)) begin
            done_q <= 1'b1;
            state_q <= HS_IDLE;
          end
        end
        HS_PROGRAM: begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == 5'(ML_PULSE_CYC - 1)) begin
            state_q <= HS_IDLE;
          end
        end
        HS_CLEAR: begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == 5'(CLEAR_CYC - 1)) begin
            state_q <= HS_IDLE;
          end
        end
        default: begin
          state_q <= HS_IDLE;
        end
      endcase
    end
  end

  assign BUS.mode_load_strobe_n = !(state_q == HS_RESET || state_q == HS_PROGRAM);
  assign BUS.refresh_disable_n = (state_q != HS_RESET);
  assign BUS.external_refresh_input_n = (state_q != HS_CLEAR);
  assign BUS.access_request_n = !ctrl_q[CTRL_REQ_A];
  assign BUS.port_b_access_request_n = !ctrl_q[CTRL_REQ_B];
  assign BUS.port_b_grant = ctrl_q[CTRL_GRANT];
  assign BUS.write_n = !ctrl_q[CTRL_WRITE];
  // extend zero low while programming by default
  assign BUS.column_extend_input_n = {~ctrl_q[CTRL_EXT_LSB+3:CTRL_EXT_LSB+1],
                                      (state_q == HS_PROGRAM) ? mode_q[MODE_EXT0_HIGH]
                                                              : !ctrl_q[CTRL_EXT_LSB]};
  assign BUS.column_increment = ctrl_q[CTRL_COLUMN_INCREMENT];
  assign BUS.row_delay_select_bit = mode_q[MODE_ROWDLY];
  assign BUS.refresh_clock_divider_bits = mode_q[MODE_DIV_LSB+3:MODE_DIV_LSB];
  assign BUS.pipeline_mode = mode_q[MODE_PIPE];
  assign BUS.scrub_mode = mode_q[MODE_SCRUB];
  assign O_PRDATA = prdata_q;
  assign O_PREADY = I_PSEL && I_PENABLE;
  assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;
endmodule

// ===== drf_asserts.sv
// pin-level checks between the controller end and the host end
// assumes one clock; the bench instantiates it beside the interface
module drf_asserts
  import drf_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  input wire logic access_request_n,
  input wire logic port_b_access_request_n,
  input wire logic port_b_grant,
  input wire logic [3:0] column_extend_input_n,
  input wire logic mode_load_strobe_n,
  input wire logic refresh_disable_n,
  input wire logic external_refresh_input_n,
  input wire logic row_delay_select_bit,
  input wire logic pipeline_mode,
  input wire logic scrub_mode,
  input wire logic we_n,
  input wire logic ras_n,
  input wire logic [3:0] cas_n
);
  logic ext_q, pipe_q, scrub_q, dly_q, gap_v_q;
  logic [4:0] hw_q;
  logic [3:0] clr_q;
  logic [8:0] gap_q;
  wire logic hwr = !mode_load_strobe_n && !refresh_disable_n;
  wire logic clr = refresh_disable_n && !external_refresh_input_n;
  wire logic rt = ext_q || pipe_q;
  wire logic no_req = access_request_n && port_b_access_request_n;
  wire logic sel_req = port_b_grant ? !port_b_access_request_n : !access_request_n;

  // mirror of what the controller latches, cleared like its config
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N || (hwr && hw_q >= 5'd15)) begin
      {ext_q, pipe_q, scrub_q, dly_q} <= 4'h0;
    end else if (!mode_load_strobe_n && refresh_disable_n) begin
      {ext_q, pipe_q, scrub_q, dly_q} <= {column_extend_input_n[0], pipeline_mode,
                                          scrub_mode, row_delay_select_bit};
    end
  end

  always_ff @(posedge I_CLOCK) begin
    hw_q <= (!I_RST_N || !hwr) ? 5'h0 : hw_q + {4'h0, hw_q != 5'h1F};
    clr_q <= (!I_RST_N || !clr) ? 4'h0 : clr_q + {3'h0, clr_q != 4'hF};
  end

  // cycles since the refresh counter was last held clear
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      gap_v_q <= 1'b0;
      gap_q <= 9'h0;
    end else if (clr && clr_q >= 4'd9) begin
      gap_v_q <= 1'b1;
      gap_q <= 9'h0;
    end else if (refresh_disable_n && gap_q != 9'h1FF) begin
      gap_q <= gap_q + 9'h1;
    end
  end

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  property p_ext_hold;
    ext_q && !scrub_q && no_req && !cas_n[0] && !column_extend_input_n[0] |=> !cas_n[0];
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("column strobe dropped");
  property p_ext_off;
    !ext_q && !scrub_q && no_req && !cas_n[0] |=> cas_n == 4'hF;
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("strobe extended");
  sequence s_gchg;
    $changed(port_b_grant) && sel_req && ras_n && $past(ras_n) && $past(ras_n, 2);
  endsequence
  property p_grant_one;
    !dly_q and s_gchg |=> !ras_n;
  endproperty
  a_grant_one: assert property (p_grant_one) else $error("row strobe not one clock");
  property p_grant_two;
    dly_q and s_gchg |=> ras_n ##1 !ras_n;
  endproperty
  a_grant_two: assert property (p_grant_two) else $error("row strobe not two clocks");
  property p_prech;
    $rose(ras_n) |=> ras_n [*2];
  endproperty
  a_prech: assert property (p_prech) else $error("precharge cut short");
  property p_route_off;
    !rt && !$past(rt) && ras_n && $past(ras_n) |-> we_n;
  endproperty
  a_route_off: assert property (p_route_off) else $error("request on write pin");
  property p_gap;
    rt && $past(rt) && gap_v_q && gap_q >= 9'd2 && gap_q <= 9'd250 |-> we_n;
  endproperty
  a_gap: assert property (p_gap) else $error("refresh request too early");
  property p_hw_len;
    hw_q != 5'h0 && !hwr |-> hw_q >= 5'd16;
  endproperty
  a_hw_len: assert property (p_hw_len) else $error("hardware reset too short");
  property p_scrub;
    scrub_q && no_req && $fell(cas_n[0]) |-> ##[1:2] cas_n == 4'hF;
  endproperty
  a_scrub: assert property (p_scrub) else $error("scrub strobe extended");
  c_grant: cover property (s_gchg);
  c_ext: cover property (ext_q && no_req && !cas_n[0]);
  c_scrub: cover property (scrub_q && $fell(cas_n[0]));
endmodule

// ===== drf_test.sv
// self-checking bench: host end and controller end joined by drf_if
// assumes apb master here; all waits bounded
module drf_test
  import drf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic dev_ras_n, dev_we_n, dev_pend, dev_cfg;
  logic [3:0] dev_cas_n;
  int err_total = 0;
  int total_checks = 0;
  always #25 clk = ~clk;

  drf_if drf_if_i();
  drf_device drf_device_i(.I_CLOCK(clk), .I_RST_N(rst_n), .BUS(drf_if_i.device),
    .O_RAS_N(dev_ras_n), .O_CAS_N(dev_cas_n), .O_WE_N(dev_we_n),
    .O_REFRESH_PENDING(dev_pend), .O_CONFIG_VALID(dev_cfg));
  drf_host drf_host_i(.I_CLOCK(clk), .I_RST_N(rst_n), .BUS(drf_if_i.host),
    .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr));
  drf_asserts drf_asserts_i(.I_CLOCK(clk), .I_RST_N(rst_n),
    .access_request_n(drf_if_i.access_request_n),
    .port_b_access_request_n(drf_if_i.port_b_access_request_n),
    .port_b_grant(drf_if_i.port_b_grant),
    .column_extend_input_n(drf_if_i.column_extend_input_n),
    .mode_load_strobe_n(drf_if_i.mode_load_strobe_n),
    .refresh_disable_n(drf_if_i.refresh_disable_n),
    .external_refresh_input_n(drf_if_i.external_refresh_input_n),
    .row_delay_select_bit(drf_if_i.row_delay_select_bit),
    .pipeline_mode(drf_if_i.pipeline_mode), .scrub_mode(drf_if_i.scrub_mode),
    .we_n(drf_if_i.we_n), .ras_n(drf_if_i.ras_n), .cas_n(drf_if_i.cas_n));

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic stuck(input string what);
    err_total++;
    $display("BAD %0t timeout %s", $time, what);
    summarize();
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) stuck("apb");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  // waits out the busy flag of a host sequence
  task automatic cmd(input int bit_no);
    logic [31:0] s;
    int n;
    wr(CMD_OFS, 32'h1 << bit_no);
    n = 0;
    do begin
      rd(STATUS_OFS, s);
      n++;
    end while (s[ST_BUSY] !== 1'b0 && n < 20);
    if (n >= 20) stuck("busy");
  endtask

  task automatic prog(input logic [31:0] m);
    wr(MODE_OFS, m);
    cmd(CMD_PROGRAM);
    cmd(CMD_CLEAR);
  endtask

  // counts edges until the chosen pin reaches the level; #1 lets the edge land
  // sel: 0 ras, 1 cas lane 0, 2 external refresh, other write pin
  task automatic edges_to(input int sel, input logic lvl, input int lim, output int n);
    logic v;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      case (sel)
        0: v = drf_if_i.ras_n;
        1: v = drf_if_i.cas_n[0];
        2: v = drf_if_i.external_refresh_input_n;
        default: v = drf_if_i.we_n;
      endcase
    end while (v !== lvl && n < lim);
    if (n >= lim) stuck("pin");
  endtask

  task automatic t_regs;
    logic [31:0] r;
    logic e;
    cmd(CMD_HWRESET);
    rd(STATUS_OFS, r);
    chk(r[ST_RESET_DONE], 1'b1, "reset done");
    chk(dev_cfg, 1'b0, "config cleared");
    rd(MODE_OFS, r);
    chk(r, MODE_RESET, "mode reset");
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1, "unmapped");
    wr(CTRL_OFS, 32'h1 << CTRL_COLUMN_INCREMENT);
    #1;
    chk(drf_if_i.column_increment, 1'b1, "column_increment pin");
    wr(CTRL_OFS, CTRL_RESET);
    $display("done regs");
  endtask

  task automatic t_ext(input logic ext0);
    logic [31:0] s;
    prog({24'h0, ext0, 7'h0});
    chk(dev_cfg, 1'b1, "config valid");
    wr(CTRL_OFS, (32'h1 << CTRL_REQ_A) | (32'h1 << CTRL_EXT_LSB));
    repeat (3) @(posedge clk);
    rd(STATUS_OFS, s);
    chk(s[ST_CAS_LSB +: 4], 4'hF, "cas on access");
    wr(CTRL_OFS, 32'h1 << CTRL_EXT_LSB);
    repeat (6) @(posedge clk);
    rd(STATUS_OFS, s);
    chk(s[ST_CAS_LSB +: 4], {3'h0, ext0}, "cas extended");
    wr(CTRL_OFS, CTRL_RESET);
    repeat (3) @(posedge clk);
    rd(STATUS_OFS, s);
    chk(s[ST_CAS_LSB +: 4], 4'h0, "cas released");
    $display("done extend %0d", ext0);
  endtask

  task automatic t_grant(input logic dly);
    int n;
    prog({31'h0, dly});
    wr(CTRL_OFS, 32'h1 << CTRL_REQ_B);
    repeat (4) @(posedge clk);
    wr(CTRL_OFS, (32'h1 << CTRL_REQ_B) | (32'h1 << CTRL_GRANT) | (32'h1 << CTRL_WRITE));
    edges_to(0, 1'b0, 10, n);
    chk(n, 1 + dly, "grant to ras");
    @(posedge clk);
    #1;
    chk(dev_we_n, 1'b0, "write pin");
    wr(CTRL_OFS, CTRL_RESET);
    $display("done grant %0d", dly);
  endtask

  task automatic t_refresh(input logic [31:0] m, input int div);
    int n, lo;
    wr(MODE_OFS, m | (div << MODE_DIV_LSB));
    cmd(CMD_PROGRAM);
    wr(CMD_OFS, 32'h1 << CMD_CLEAR);
    edges_to(2, 1'b1, 40, n);
    edges_to(3, 1'b0, 400, n);
    lo = REFRESH_MIN_CYC + 2 * div;
    chk(n >= lo && n <= lo + 4, 1'b1, "request delay");
    chk({dev_pend, dev_ras_n, dev_we_n}, 3'h0, "refresh start");
    $display("done refresh %0d", div);
  endtask

  task automatic t_scrub;
    int n;
    prog((32'h1 << MODE_SCRUB) | (32'h1 << MODE_EXT0_HIGH));
    wr(CTRL_OFS, 32'hF << CTRL_EXT_LSB);
    edges_to(1, 1'b0, 400, n);
    repeat (3) @(posedge clk);
    chk(drf_if_i.cas_n, 4'hF, "scrub cas");
    chk({dev_ras_n, dev_cas_n}, 5'h1F, "scrub pins");
    wr(CTRL_OFS, CTRL_RESET);
    $display("done scrub");
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_ext(1'b1);
    t_ext(1'b0);
    t_grant(1'b0);
    t_grant(1'b1);
    t_refresh(32'h1 << MODE_PIPE, 0);
    t_refresh(32'h1 << MODE_EXT0_HIGH, 15);
    t_scrub();
    summarize();
  end
endmodule
